// ==== verilog/detect_gpio_pin_function_select.sv ====
/*
  role selection for the two multipurpose pins, their apb registers and
  the shadow transfer that the transfer role or software starts.
  assumes pin inputs are asynchronous; the pad applies the pull-down
  and resolves the wire from the output enable.

  // Contract
  // - pin A code 000 alarm, 001 frame clock
  // - pin B code 000 alarm, 001 frame clock
  // - pin B code 110 uses upper secondary nibble
  // - pin A code 110 uses lower secondary nibble
  // - pin B code 111 pulled-down input, reset
  // - pin A code 111 pulled-down input, reset
  // - pin B nibble ignored unless code 110
  // - pin A nibble ignored unless code 110
  // - pin B nibble 0000 channel, 0001 transfer
  // - pin A nibble 0000 channel, 0001 transfer
  // - nibble 1000 drives master trigger out
  // - nibble 1001 accepts external slave trigger
  // - transfer copies pending settings, then self-clears
  // - pin B primary at bits 5:3, reset 111
*/
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// one pin: role decode, input synchroniser, output drive
module pin_role_slice
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] primary,
  input  wire logic [3:0] secondary,
  input  wire logic       levelAlarm,
  input  wire logic       multiframeClock,
  input  wire logic       masterNextTrigger,
  input  wire logic       pinIn,
  output logic            pinOut,
  output logic            pinOe,
  output logic            pinPullDown,
  output logic            pinLevel,
  output logic            channelSelect,
  output logic            transferRise,
  output logic            slaveNextTrigger
);
  pin_role_pkg::role_type deferRole;
  pin_role_pkg::role_type role;
  logic                   syncFirst;
  logic                   syncSecond;
  logic                   syncLast;
  logic                   isOutput;
  logic                   next_pinOut;

  // secondary role, only consulted under the defer code
  assign deferRole =
    (secondary == pin_role_pkg::SEC_CHANNEL)  ? pin_role_pkg::ROLE_CHANNEL_SEL :
    (secondary == pin_role_pkg::SEC_TRANSFER) ? pin_role_pkg::ROLE_TRANSFER :
    (secondary == pin_role_pkg::SEC_MASTER)   ? pin_role_pkg::ROLE_MASTER_TRIG :
    (secondary == pin_role_pkg::SEC_SLAVE)    ? pin_role_pkg::ROLE_SLAVE_TRIG :
    pin_role_pkg::ROLE_DISABLED;

  // primary select; unlisted codes fall back to the safe input
  assign role =
    (primary == pin_role_pkg::PRI_ALARM) ? pin_role_pkg::ROLE_ALARM :
    (primary == pin_role_pkg::PRI_FRAME) ? pin_role_pkg::ROLE_FRAME_CLOCK :
    (primary == pin_role_pkg::PRI_DEFER) ? deferRole :
    pin_role_pkg::ROLE_DISABLED;

  // drive only in the three output roles
  assign isOutput = (role == pin_role_pkg::ROLE_ALARM)
                 || (role == pin_role_pkg::ROLE_FRAME_CLOCK)
                 || (role == pin_role_pkg::ROLE_MASTER_TRIG);

  // output value mux, registered so the pad sees no decode glitches
  assign next_pinOut =
    (role == pin_role_pkg::ROLE_ALARM)       ? levelAlarm :
    (role == pin_role_pkg::ROLE_FRAME_CLOCK) ? multiframeClock :
    (role == pin_role_pkg::ROLE_MASTER_TRIG) ? masterNextTrigger :
    1'b0;

  // output flops; disabled after reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pinOut      <= 1'b0;
      pinOe       <= 1'b0;
      pinPullDown <= 1'b1;
    end
    else
    begin
      pinOut      <= next_pinOut;
      pinOe       <= isOutput;
      pinPullDown <= !isOutput;
    end
  end

  // two-flop synchroniser plus one stage for edge detection
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      syncFirst  <= 1'b0;
      syncSecond <= 1'b0;
      syncLast   <= 1'b0;
    end
    else
    begin
      syncFirst  <= pinIn;
      syncSecond <= syncFirst;
      syncLast   <= syncSecond;
    end
  end

  // role inputs are gated by role so a stray level cannot leak through; pinLevel is not gated
  assign pinLevel         = syncSecond;
  assign channelSelect    = (role == pin_role_pkg::ROLE_CHANNEL_SEL) && syncSecond;
  assign slaveNextTrigger = (role == pin_role_pkg::ROLE_SLAVE_TRIG) && syncSecond;
  assign transferRise     = (role == pin_role_pkg::ROLE_TRANSFER)
                         && syncSecond && !syncLast;
endmodule : pin_role_slice

////////////////////////////////////////////////////////////////////////
// top: apb registers, two pin slices, shadow transfer
module detect_gpio_pin_function_select
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        levelAlarmA,
  input  wire logic        levelAlarmB,
  input  wire logic        multiframeClock,
  input  wire logic        masterNextTriggerOut,
  input  wire logic        multipurposePinAIn,
  output logic             multipurposePinAOut,
  output logic             multipurposePinAOe,
  output logic             multipurposePinAPullDown,
  input  wire logic        multipurposePinBIn,
  output logic             multipurposePinBOut,
  output logic             multipurposePinBOe,
  output logic             multipurposePinBPullDown,
  output logic             channelSelectA,
  output logic             channelSelectB,
  output logic             slaveNextTriggerIn,
  input  wire logic [31:0] pendingSettings,
  output logic [31:0]      activeSettings,
  output logic             transferStrobe
);
  logic [7:0]  primaryRole;
  logic [7:0]  secondaryRole;
  logic        transferPending;
  logic        pinLevelA;
  logic        pinLevelB;
  logic        transferRiseA;
  logic        transferRiseB;
  logic        slaveTriggerA;
  logic        slaveTriggerB;
  logic        accessPhase;
  logic        setupPhase;
  logic        writeStrobe;
  logic [9:0]  wordIndex;
  logic        hitTransfer;
  logic        hitPrimary;
  logic        hitSecondary;
  logic        hitStatus;
  logic        hitActive;
  logic        mapped;
  logic        alignedOk;
  logic        softTransfer;
  logic        setTransfer;
  logic [31:0] next_prdata;
  logic [31:0] statusWord;

  //////////////////////////////////////////////////////////////////////
  // address decode; word index is the printed offset
  assign wordIndex    = paddr[11:pin_role_pkg::BYTE_SHIFT];
  assign alignedOk    = (paddr[1:0] == 2'h0);
  assign hitTransfer  = alignedOk && (wordIndex == {2'h0, pin_role_pkg::TRANSFER_INDEX});
  assign hitPrimary   = alignedOk && (wordIndex == {2'h0, pin_role_pkg::PRIMARY_INDEX});
  assign hitSecondary = alignedOk && (wordIndex == {2'h0, pin_role_pkg::SECONDARY_INDEX});
  assign hitStatus    = alignedOk && (wordIndex == {2'h0, pin_role_pkg::PIN_STATUS_INDEX});
  assign hitActive    = alignedOk && (wordIndex == {2'h0, pin_role_pkg::ACTIVE_INDEX});
  assign mapped       = hitTransfer || hitPrimary || hitSecondary || hitStatus || hitActive;

  // zero-wait slave; read data is captured in the setup cycle
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign writeStrobe = accessPhase && pwrite && mapped;
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !mapped;

  // read-only view of what the pins see and drive
  assign statusWord = {26'h0, transferPending, multipurposePinBOe, multipurposePinAOe,
                       pinLevelB, pinLevelA, 1'b0};

  // read mux; unmapped and reserved bits read zero
  assign next_prdata =
    hitTransfer  ? {31'h0, transferPending} :
    hitPrimary   ? {24'h0, primaryRole} :
    hitSecondary ? {24'h0, secondaryRole} :
    hitStatus    ? statusWord :
    hitActive    ? activeSettings :
    32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (setupPhase && !pwrite)
      prdata <= next_prdata;
  end

  //////////////////////////////////////////////////////////////////////
  // role select registers; both primary fields reset to disabled
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      primaryRole   <= pin_role_pkg::PRIMARY_RESET;
      secondaryRole <= pin_role_pkg::SECONDARY_RESET;
    end
    else
    begin
      if (writeStrobe && hitPrimary)
        primaryRole <= pwdata[7:0];
      if (writeStrobe && hitSecondary)
        secondaryRole <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin slices; field slices follow the register layout
  pin_role_slice pinA
  (
    .clock             (clock),
    .rst_n             (rst_n),
    .primary           (primaryRole[pin_role_pkg::PRIMARY_A_LSB +: 3]),
    .secondary         (secondaryRole[pin_role_pkg::SECONDARY_A_LSB +: 4]),
    .levelAlarm        (levelAlarmA),
    .multiframeClock   (multiframeClock),
    .masterNextTrigger (masterNextTriggerOut),
    .pinIn             (multipurposePinAIn),
    .pinOut            (multipurposePinAOut),
    .pinOe             (multipurposePinAOe),
    .pinPullDown       (multipurposePinAPullDown),
    .pinLevel          (pinLevelA),
    .channelSelect     (channelSelectA),
    .transferRise      (transferRiseA),
    .slaveNextTrigger  (slaveTriggerA)
  );

  pin_role_slice pinB
  (
    .clock             (clock),
    .rst_n             (rst_n),
    .primary           (primaryRole[pin_role_pkg::PRIMARY_B_LSB +: 3]),
    .secondary         (secondaryRole[pin_role_pkg::SECONDARY_B_LSB +: 4]),
    .levelAlarm        (levelAlarmB),
    .multiframeClock   (multiframeClock),
    .masterNextTrigger (masterNextTriggerOut),
    .pinIn             (multipurposePinBIn),
    .pinOut            (multipurposePinBOut),
    .pinOe             (multipurposePinBOe),
    .pinPullDown       (multipurposePinBPullDown),
    .pinLevel          (pinLevelB),
    .channelSelect     (channelSelectB),
    .transferRise      (transferRiseB),
    .slaveNextTrigger  (slaveTriggerB)
  );

  // either pin may carry the external trigger from the master
  assign slaveNextTriggerIn = slaveTriggerA || slaveTriggerB;

  //////////////////////////////////////////////////////////////////////
  // shadow transfer; a new request in the completing cycle is kept
  assign softTransfer = writeStrobe && hitTransfer && pwdata[pin_role_pkg::TRANSFER_BIT];
  assign setTransfer  = softTransfer || transferRiseA || transferRiseB;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      transferPending <= 1'b0;
    else if (setTransfer)
      transferPending <= 1'b1;
    else if (transferPending)
      transferPending <= 1'b0;
  end

  // copy pending settings to the active set one cycle after the request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      activeSettings <= pin_role_pkg::ACTIVE_RESET;
      transferStrobe <= 1'b0;
    end
    else
    begin
      transferStrobe <= transferPending;
      if (transferPending)
        activeSettings <= pendingSettings;
    end
  end
endmodule : detect_gpio_pin_function_select

// ==== include/pin_role_pkg.sv ====
/*
  register map, field layout, reset values and pin roles of the
  multipurpose pin role selector.
  assumes a 32-bit apb slave with word-aligned registers.
*/
package pin_role_pkg;
  // printed offsets are register indexes, byte address is four times that
  localparam logic [7:0] TRANSFER_INDEX  = 8'h0F;
  localparam logic [7:0] PRIMARY_INDEX   = 8'h40;
  localparam logic [7:0] SECONDARY_INDEX = 8'h41;
  localparam logic [7:0] PIN_STATUS_INDEX = 8'h43;
  localparam logic [7:0] ACTIVE_INDEX    = 8'h44;
  localparam int         BYTE_SHIFT      = 2;

  // primary field positions
  localparam int PRIMARY_B_LSB = 3;
  localparam int PRIMARY_A_LSB = 0;
  localparam int POWER_LSB     = 6;
  // secondary field positions
  localparam int SECONDARY_B_LSB = 4;
  localparam int SECONDARY_A_LSB = 0;
  localparam int TRANSFER_BIT    = 0;

  localparam logic [7:0] PRIMARY_RESET   = 8'h3F;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [31:0] ACTIVE_RESET   = 32'h0000_0000;

  // primary codes
  localparam logic [2:0] PRI_ALARM    = 3'h0;
  localparam logic [2:0] PRI_FRAME    = 3'h1;
  localparam logic [2:0] PRI_DEFER    = 3'h6;
  localparam logic [2:0] PRI_DISABLED = 3'h7;
  // secondary codes
  localparam logic [3:0] SEC_CHANNEL  = 4'h0;
  localparam logic [3:0] SEC_TRANSFER = 4'h1;
  localparam logic [3:0] SEC_MASTER   = 4'h8;
  localparam logic [3:0] SEC_SLAVE    = 4'h9;

  typedef enum logic [2:0] {
    ROLE_ALARM,
    ROLE_FRAME_CLOCK,
    ROLE_CHANNEL_SEL,
    ROLE_TRANSFER,
    ROLE_MASTER_TRIG,
    ROLE_SLAVE_TRIG,
    ROLE_DISABLED
  } role_type;
endpackage : pin_role_pkg

// ==== testbench/pin_role_props.sv ====
/*
  checker for the pin role selector: shadows both role registers from
  apb writes and ties pin drive to them.
  assumes a zero-wait apb slave whose write lands at the access edge.
*/
`timescale 1ns/1ps
module pin_role_props
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        levelAlarmA,
  input wire logic        multiframeClock,
  input wire logic        masterNextTriggerOut,
  input wire logic [31:0] pendingSettings,
  input wire logic        multipurposePinAOut,
  input wire logic        multipurposePinAOe,
  input wire logic        multipurposePinAPullDown,
  input wire logic        multipurposePinBOut,
  input wire logic        multipurposePinBOe,
  input wire logic        multipurposePinBPullDown,
  input wire logic [31:0] activeSettings,
  input wire logic        transferStrobe
);
  logic [7:0] pri;
  logic [7:0] sec;
  // field views and the completed-write condition
  wire logic       wr   = psel && penable && pwrite && pready;
  wire logic [2:0] priA = pri[2:0];
  wire logic [2:0] priB = pri[5:3];
  wire logic [3:0] secA = sec[3:0];
  wire logic [3:0] secB = sec[7:4];
  wire logic       resB = (priB inside {[3'h2:3'h5]}) ||
                          (priB == 3'h6 && !(secB inside {4'h0, 4'h1, 4'h8, 4'h9}));

  ////////////////////////////////////////////////////////////////////
  // shadow registers, so checks never depend on the design's own copy
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pri <= pin_role_pkg::PRIMARY_RESET;
      sec <= pin_role_pkg::SECONDARY_RESET;
    end
    else if (wr && paddr == 12'h100)
      pri <= pwdata[7:0];
    else if (wr && paddr == 12'h104)
      sec <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence xferReq;
    wr && paddr == 12'h03C && pwdata[0];
  endsequence
  property offWhen(cond, oe, pd);
    cond |=> !oe && pd;
  endproperty

  idle_pin_a_a: assert property (offWhen(priA == 3'h7,
    multipurposePinAOe, multipurposePinAPullDown)) else $error("pin a not idle");
  idle_pin_b_a: assert property (offWhen(priB == 3'h7,
    multipurposePinBOe, multipurposePinBPullDown)) else $error("pin b not idle");
  reserved_off_a: assert property (offWhen(resB,
    multipurposePinBOe, multipurposePinBPullDown)) else $error("reserved b drives");
  alarm_route_a: assert property (priA == 3'h0 |=> multipurposePinAOe &&
    multipurposePinAOut == $past(levelAlarmA)) else $error("alarm not on pin a");
  frame_route_a: assert property (priB == 3'h1 |=> multipurposePinBOe &&
    multipurposePinBOut == $past(multiframeClock)) else $error("frame clock not on b");
  master_out_a: assert property (priA == 3'h6 && secA == 4'h8 |=>
    multipurposePinAOe && multipurposePinAOut == $past(masterNextTriggerOut))
    else $error("master trigger not on a");
  input_role_a: assert property (priA == 3'h6 && secA inside {4'h0, 4'h1, 4'h9}
    |-> ##1 !multipurposePinAOe) else $error("pin a driven in input role");
  copy_strobe_a: assert property (xferReq |-> ##2
    activeSettings == $past(pendingSettings) ##[0:1] transferStrobe)
    else $error("transfer copy or strobe missing");
endmodule : pin_role_props

bind detect_gpio_pin_function_select pin_role_props u_props
(
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .paddr(paddr), .pwdata(pwdata), .levelAlarmA(levelAlarmA),
  .multiframeClock(multiframeClock), .masterNextTriggerOut(masterNextTriggerOut),
  .pendingSettings(pendingSettings), .multipurposePinAOut(multipurposePinAOut),
  .multipurposePinAOe(multipurposePinAOe), .multipurposePinAPullDown(multipurposePinAPullDown),
  .multipurposePinBOut(multipurposePinBOut), .multipurposePinBOe(multipurposePinBOe),
  .multipurposePinBPullDown(multipurposePinBPullDown), .activeSettings(activeSettings),
  .transferStrobe(transferStrobe)
);

// ==== testbench/pin_partner.sv ====
/*
  far side of the two multipurpose pins: a controller that may drive a
  pin while the selector leaves it as an input.
  assumes the selector's output enable wins the wire when high.
*/
`timescale 1ns/1ps
module pin_partner
(
  input  wire logic clock,
  input  wire logic aOut,
  input  wire logic aOe,
  input  wire logic aPull,
  input  wire logic bOut,
  input  wire logic bOe,
  input  wire logic bPull,
  input  wire logic driveA,
  input  wire logic driveB,
  input  wire logic levA,
  input  wire logic levB,
  output logic      pinA,
  output logic      pinB
);
  logic lastA;
  logic lastB;
  // wire level: device, then controller, then pull-down; a floating
  // line toggles so a stale level can never pass for a driven one
  assign pinA = aOe ? aOut : driveA ? levA : aPull ? 1'b0 : ~lastA;
  assign pinB = bOe ? bOut : driveB ? levB : bPull ? 1'b0 : ~lastB;

  // last wire level, only used while floating
  always_ff @(posedge clock)
  begin
    lastA <= pinA;
    lastB <= pinB;
  end
endmodule : pin_partner

// ==== testbench/detect_gpio_pin_function_select_tb.sv ====
/*
  bench for the pin role selector: apb tasks, a role table, input roles
  through the partner, and the shadow transfer.
  assumes a zero-wait apb slave at byte address four times the index.
*/
`timescale 1ns/1ps
module detect_gpio_pin_function_select_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, pending = 32'h0, active;
  // master trigger held high so a missing route cannot pass as a low pin
  logic        alarmA = 1'b0, alarmB = 1'b1, frame = 1'b1, master = 1'b1;
  logic        pinA, pinB, aOut, aOe, aPd, bOut, bOe, bPd, chA, chB, slave, strobe, rdErr;
  logic        driveA = 1'b0, driveB = 1'b0, levA = 1'b0, levB = 1'b0;
  int          errors = 0;
  int          nTests = 0;
  // roles per row: primary, secondary, expected enables and drive
  logic [7:0]  priTab [6] = '{8'h00, 8'h09, 8'h36, 8'h3F, 8'h12, 8'h36};
  logic [7:0]  secTab [6] = '{8'h88, 8'h00, 8'h88, 8'h88, 8'h00, 8'h32};
  logic [1:0]  oeTab  [6] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
  logic [1:0]  outTab [6] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};

  always #4 clock = ~clock;

  detect_gpio_pin_function_select u_dut
  (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .levelAlarmA(alarmA), .levelAlarmB(alarmB), .multiframeClock(frame),
    .masterNextTriggerOut(master), .multipurposePinAIn(pinA), .multipurposePinAOut(aOut),
    .multipurposePinAOe(aOe), .multipurposePinAPullDown(aPd), .multipurposePinBIn(pinB),
    .multipurposePinBOut(bOut), .multipurposePinBOe(bOe), .multipurposePinBPullDown(bPd),
    .channelSelectA(chA), .channelSelectB(chB), .slaveNextTriggerIn(slave),
    .pendingSettings(pending), .activeSettings(active), .transferStrobe(strobe)
  );

  pin_partner u_partner
  (
    .clock(clock), .aOut(aOut), .aOe(aOe), .aPull(aPd), .bOut(bOut), .bOe(bOe),
    .bPull(bPd), .driveA(driveA), .driveB(driveB), .levA(levA), .levB(levB),
    .pinA(pinA), .pinB(pinB)
  );

  ////////////////////////////////////////////////////////////////////
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd      = prdata;
    rdErr   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the roughly 120 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clock);
    errors++;
    final_report();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 12'h100, 32'h0);
    check("primary reset", rd, 32'h3F);
    apb(1'b0, 12'h104, 32'h0);
    check("secondary reset", rd, 32'h0);
    check("idle pins", {aOe, aPd, bOe, bPd}, 4'h5);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, 12'h100, {24'h0, priTab[i]});
      apb(1'b1, 12'h104, {24'h0, secTab[i]});
      repeat (2) @(posedge clock);
      check("pin oe", {bOe, aOe}, oeTab[i]);
      check("pin pull", {bPd, aPd}, 2'(~oeTab[i]));
      check("pin out", {bOut & bOe, aOut & aOe}, outTab[i]);
    end
    $display("role table done");
    apb(1'b1, 12'h104, 32'h00);
    driveA <= 1'b1;
    driveB <= 1'b1;
    levA   <= 1'b1;
    repeat (4) @(posedge clock);
    check("channel select", {chB, chA, bOe, aOe}, 4'h4);
    levA <= 1'b0;
    levB <= 1'b1;
    repeat (4) @(posedge clock);
    check("channel select", {chB, chA}, 2'h2);
    apb(1'b1, 12'h104, 32'h99);
    repeat (4) @(posedge clock);
    check("slave trigger", slave, 1'b1);
    levB <= 1'b0;
    repeat (4) @(posedge clock);
    check("slave trigger", slave, 1'b0);
    $display("input roles done");
    pending <= 32'hA5C3_0F1E;
    apb(1'b1, 12'h03C, 32'h1);
    // copy and strobe stand one cycle, two edges after the write lands
    repeat (2) @(posedge clock);
    check("transfer strobe", strobe, 1'b1);
    check("active copy", active, 32'hA5C3_0F1E);
    @(posedge clock);
    check("strobe one cycle", strobe, 1'b0);
    apb(1'b0, 12'h03C, 32'h0);
    check("transfer self clear", rd[0], 1'b0);
    apb(1'b1, 12'h104, 32'h11);
    pending <= 32'h1234_5678;
    levA    <= 1'b1;
    repeat (6) @(posedge clock);
    check("pin transfer", active, 32'h1234_5678);
    apb(1'b0, 12'h110, 32'h0);
    check("active read", rd, 32'h1234_5678);
    apb(1'b0, 12'h200, 32'h0);
    check("unmapped error", rdErr, 1'b1);
    check("unmapped read", rd, 32'h0000_0000);
    $display("transfer test done");
    final_report();
  end
endmodule : detect_gpio_pin_function_select_tb
